/* core/die_link_port_pkg.sv */
// Constants, field layouts and carrier types for the die-link port pin control block.
package die_link_port_pkg;

    // Register indices; byte address equals the index on this plain port.
    localparam logic [7:0] NARROW_DATA_ADDR = 8'h04;
    localparam logic [7:0] WIDE_DATA_ADDR = 8'h05;
    localparam logic [7:0] NARROW_DIR_ADDR = 8'h06;
    localparam logic [7:0] WIDE_DIR_ADDR = 8'h07;

    // Port widths and reset values.
    localparam int NARROW_WIDTH = 2;
    localparam int WIDE_WIDTH = 8;
    localparam logic [7:0] PORT_RESET = 8'h00;

    // Field positions on the narrow port.
    localparam int CLOCK_BIT = 0;
    localparam int INTERRUPT_BIT = 1;

    // Mask of the wide pins taken in four-bit mode.
    localparam logic [7:0] NIBBLE_MASK = 8'h0f;
    localparam logic [7:0] FULL_MASK = 8'hff;

    // Link data width selection.
    typedef enum logic [0:0] {
        LINK_NIBBLE = 1'b0,
        LINK_BYTE = 1'b1
    } link_width_e;

    // Pin drive bundle: value and output enable for one port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;

    // Register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

/* core/die_link_port_pin_control.sv */
// Pin multiplexing between general purpose I/O and the die-link interface for the narrow and wide ports.
`timescale 1ns/1ps
module die_link_port_pin_control
    import die_link_port_pkg::*;
#(
    parameter int NARROW_PINS = NARROW_WIDTH,
    parameter int WIDE_PINS = WIDE_WIDTH
) (
    // Clock, reset and clock enable.
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clkEn,
    // Register port.
    input wire reg_req_s regReq,
    output logic [7:0] regRdata,
    // Die-link interface controls.
    input wire logic linkEnable,
    input wire link_width_e linkWidth,
    input wire logic linkClockClaim,
    input wire logic linkIntClaim,
    input wire logic [1:0] linkNarrowOut,
    input wire logic [1:0] linkNarrowOe,
    input wire logic [7:0] linkWideOut,
    input wire logic [7:0] linkWideOe,
    output logic [1:0] linkNarrowIn,
    output logic [7:0] linkWideIn,
    // Pads.
    input wire logic [1:0] narrowPinIn,
    input wire logic [7:0] widePinIn,
    output pin_drive_s narrowPin,
    output pin_drive_s widePin
);

    // Only the documented widths are served by the fixed address map.
    // The check runs at elaboration, so a wrong width never reaches simulation or a netlist.
    // Wider ports would need more register addresses, which this map does not have.
    if (NARROW_PINS != 2 || WIDE_PINS != 8) begin : g_width_check
        $error("die_link_port_pin_control supports only 2 narrow and 8 wide pins.");
    end

    // Stored registers; narrow ones hold only the two implemented bits.
    logic [1:0] narrowData_q;
    logic [1:0] narrowDir_q;
    logic [7:0] wideData_q;
    logic [7:0] wideDir_q;
    // Two-stage synchronisers for the pad levels.
    logic [1:0] narrowMeta_q;
    logic [1:0] narrowSync_q;
    logic [7:0] wideMeta_q;
    logic [7:0] wideSync_q;
    // Registered outputs.
    logic [7:0] regRdata_q;
    pin_drive_s narrowPin_q;
    pin_drive_s widePin_q;
    logic [1:0] linkNarrowIn_q;
    logic [7:0] linkWideIn_q;

    // Register decode, shared by write and read paths.
    function automatic logic hit(input reg_req_s r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    wire wrNarrowData = regReq.wr && hit(regReq, NARROW_DATA_ADDR);
    wire wrWideData = regReq.wr && hit(regReq, WIDE_DATA_ADDR);
    wire wrNarrowDir = regReq.wr && hit(regReq, NARROW_DIR_ADDR);
    wire wrWideDir = regReq.wr && hit(regReq, WIDE_DIR_ADDR);

    // Which pins the link owns; claims are gated by the master enable.
    wire [1:0] narrowClaim = {linkEnable && linkIntClaim, linkEnable && linkClockClaim};
    wire [7:0] wideMask = (linkWidth == LINK_BYTE) ? FULL_MASK : NIBBLE_MASK;
    wire [7:0] wideClaim = linkEnable ? wideMask : 8'h00;

    // Pin drive: link value and enable on claimed pins, register bits elsewhere.
    wire [1:0] narrowOutD = (narrowClaim & linkNarrowOut) | (~narrowClaim & narrowData_q);
    wire [1:0] narrowOeD = (narrowClaim & linkNarrowOe) | (~narrowClaim & narrowDir_q);
    wire [7:0] wideOutD = (wideClaim & linkWideOut) | (~wideClaim & wideData_q);
    wire [7:0] wideOeD = (wideClaim & linkWideOe) | (~wideClaim & wideDir_q);

    // Data reads mix stored bits for outputs with synchronised levels for inputs.
    wire [1:0] narrowReadBits = (narrowDir_q & narrowData_q) | (~narrowDir_q & narrowSync_q);
    wire [7:0] wideReadBits = (wideDir_q & wideData_q) | (~wideDir_q & wideSync_q);

    // Read multiplexer; unmapped addresses, including reserved ones, read zero.
    wire [7:0] readMux =
        hit(regReq, NARROW_DATA_ADDR) ? {6'h00, narrowReadBits} :
        hit(regReq, WIDE_DATA_ADDR) ? wideReadBits :
        hit(regReq, NARROW_DIR_ADDR) ? {6'h00, narrowDir_q} :
        hit(regReq, WIDE_DIR_ADDR) ? wideDir_q : 8'h00;
    wire [7:0] regRdataD = regReq.rd ? readMux : 8'h00;

    // Software registers; writes land whatever the link is doing, so direction bits survive a claim.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            narrowData_q <= PORT_RESET[1:0];
            narrowDir_q <= PORT_RESET[1:0];
            wideData_q <= PORT_RESET;
            wideDir_q <= PORT_RESET;
        end else if (clkEn) begin
            if (wrNarrowData) begin
                narrowData_q <= regReq.wdata[1:0];
            end
            if (wrWideData) begin
                wideData_q <= regReq.wdata;
            end
            if (wrNarrowDir) begin
                narrowDir_q <= regReq.wdata[1:0];
            end
            if (wrWideDir) begin
                wideDir_q <= regReq.wdata;
            end
        end
    end

    // Pad synchronisers; only the second stage feeds logic, to keep metastability contained.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            narrowMeta_q <= 2'h0;
            narrowSync_q <= 2'h0;
            wideMeta_q <= 8'h00;
            wideSync_q <= 8'h00;
        end else if (clkEn) begin
            narrowMeta_q <= narrowPinIn;
            narrowSync_q <= narrowMeta_q;
            wideMeta_q <= widePinIn;
            wideSync_q <= wideMeta_q;
        end
    end

    // Output flops; pin drive costs one cycle of latency so every output is registered.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdata_q <= 8'h00;
            narrowPin_q <= '0;
            widePin_q <= '0;
            linkNarrowIn_q <= 2'h0;
            linkWideIn_q <= 8'h00;
        end else if (clkEn) begin
            regRdata_q <= regRdataD;
            narrowPin_q <= '{out: {6'h00, narrowOutD}, oe: {6'h00, narrowOeD}};
            widePin_q <= '{out: wideOutD, oe: wideOeD};
            linkNarrowIn_q <= narrowSync_q & narrowClaim;
            linkWideIn_q <= wideSync_q & wideClaim;
        end
    end

    assign regRdata = regRdata_q;
    assign narrowPin = narrowPin_q;
    assign widePin = widePin_q;
    assign linkNarrowIn = linkNarrowIn_q;
    assign linkWideIn = linkWideIn_q;

    // Checks on the behaviour above.
    narrow_high_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        narrowPin.oe[7:2] == 6'h00 && narrowPin.out[7:2] == 6'h00)
        else $error("Narrow port upper bits driven.");
    nibble_upper_free_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkWidth == LINK_NIBBLE |=> widePin.oe[7:4] == $past(wideDir_q[7:4]))
        else $error("Upper wide pins not general purpose in four-bit mode.");
    byte_claim_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkWidth == LINK_BYTE |=> widePin.oe == $past(linkWideOe))
        else $error("Wide port not handed to link in eight-bit mode.");
    gpio_dir_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && !linkEnable |=> widePin.oe == $past(wideDir_q) && narrowPin.oe[1:0] == $past(narrowDir_q))
        else $error("General purpose direction not applied.");
    int_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkIntClaim |=> narrowPin.out[1] == $past(linkNarrowOut[1]))
        else $error("Interrupt pin not routed to link.");
    clk_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkClockClaim |=> narrowPin.out[0] == $past(linkNarrowOut[0]))
        else $error("Clock pin not routed to link.");
    dir_kept_a: assert property (@(posedge clk_sys) disable iff (srst)
        !wrWideDir && linkEnable |=> wideDir_q == $past(wideDir_q))
        else $error("Direction register changed by link claim.");
    out_readback_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && regReq.rd && hit(regReq, WIDE_DATA_ADDR) && wideDir_q == 8'hff |=> regRdata == $past(wideData_q))
        else $error("Output pin read did not return register.");
    write_any_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && wrNarrowDir |=> narrowDir_q == $past(regReq.wdata[1:0]))
        else $error("Direction write not accepted.");

    // Further checks: register access, readback, link hand-back and per-pin routing.
    // Every check compares an output or a stored register one edge after the inputs that launched it,
    // because every output of this block comes from a flip-flop.

    // Register writes land on the next edge whatever the link is doing.
    wide_dir_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && wrWideDir
        |=> wideDir_q == $past(regReq.wdata))
        else $error("Wide direction write not accepted.");

    // A data write must not wait for the link to let go of the pin.
    wide_data_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && wrWideData
        |=> wideData_q == $past(regReq.wdata))
        else $error("Wide data write not accepted.");

    // Narrow data keeps only the two implemented bits of the write.
    narrow_data_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && wrNarrowData
        |=> narrowData_q == $past(regReq.wdata[1:0]))
        else $error("Narrow data write not accepted.");

    // Direction reads of the narrow port show zeros above bit one.
    narrow_dir_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && regReq.rd && hit(regReq, NARROW_DIR_ADDR)
        |=> regRdata == {6'h00, $past(narrowDir_q)})
        else $error("Narrow direction read wrong.");

    // The wide direction register reads back even while the link owns the pins.
    wide_dir_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && regReq.rd && hit(regReq, WIDE_DIR_ADDR)
        |=> regRdata == $past(wideDir_q))
        else $error("Wide direction read wrong.");

    // With every wide pin an input, a data read returns the synchronised pad levels.
    wide_input_read_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && regReq.rd && hit(regReq, WIDE_DATA_ADDR) && wideDir_q == 8'h00
        |=> regRdata == $past(wideSync_q))
        else $error("Input pin read did not return pad level.");

    // Link off: narrow pins follow their data register.
    narrow_gpio_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && !linkEnable
        |=> narrowPin.out[1:0] == $past(narrowData_q))
        else $error("Narrow pins not general purpose with link off.");

    // Link off: nothing is handed back to the link, so a stray pad level cannot reach it.
    link_in_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && !linkEnable
        |=> linkWideIn == 8'h00 && linkNarrowIn == 2'h0)
        else $error("Link input active with link off.");

    // Eight-bit mode: the link sees every synchronised wide pad level.
    byte_in_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkWidth == LINK_BYTE
        |=> linkWideIn == $past(wideSync_q))
        else $error("Wide pad levels not handed to link in eight-bit mode.");

    // Four-bit mode: only the low nibble reaches the link; the upper pins stay with software.
    nibble_in_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkWidth == LINK_NIBBLE
        |=> linkWideIn[7:4] == 4'h0 && linkWideIn[3:0] == $past(wideSync_q[3:0]))
        else $error("Link input wrong in four-bit mode.");

    // The narrow direction register survives a claim as well.
    narrow_dir_kept_a: assert property (@(posedge clk_sys) disable iff (srst)
        !wrNarrowDir && linkEnable
        |=> narrowDir_q == $past(narrowDir_q))
        else $error("Narrow direction register changed by link claim.");

    // The interrupt pin takes its direction from the link while claimed.
    int_dir_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkIntClaim
        |=> narrowPin.oe[1] == $past(linkNarrowOe[1]))
        else $error("Interrupt pin direction not set by link.");

    // The clock pin likewise takes its direction from the link.
    clk_dir_a: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && linkEnable && linkClockClaim
        |=> narrowPin.oe[0] == $past(linkNarrowOe[0]))
        else $error("Clock pin direction not set by link.");

    // Per-pin checks on the wide port; one copy per pin keeps a single failing pin easy to spot.
    for (genvar i = 0; i < WIDE_PINS; i++) begin : g_wide_check
        // Readback picks register or pad bit by the direction bit.
        wide_bit_read_a: assert property (@(posedge clk_sys) disable iff (srst)
            clkEn && regReq.rd && hit(regReq, WIDE_DATA_ADDR)
            |=> regRdata[i] == ($past(wideDir_q[i]) ? $past(wideData_q[i]) : $past(wideSync_q[i])))
            else $error("Wide pin readback wrong.");

        // An unclaimed pin is plain general purpose I/O.
        wide_bit_gpio_a: assert property (@(posedge clk_sys) disable iff (srst)
            clkEn && !wideClaim[i]
            |=> widePin.out[i] == $past(wideData_q[i])
            && widePin.oe[i] == $past(wideDir_q[i]))
            else $error("Unclaimed wide pin not general purpose.");

        // A claimed pin carries the link's value and direction.
        wide_bit_link_a: assert property (@(posedge clk_sys) disable iff (srst)
            clkEn && wideClaim[i]
            |=> widePin.out[i] == $past(linkWideOut[i])
            && widePin.oe[i] == $past(linkWideOe[i]))
            else $error("Claimed wide pin not driven by link.");
    end

    // Per-pin checks on the narrow port, in the same shape as the wide ones.
    for (genvar i = 0; i < NARROW_PINS; i++) begin : g_narrow_check
        // Readback picks register or pad bit by the direction bit.
        narrow_bit_read_a: assert property (@(posedge clk_sys) disable iff (srst)
            clkEn && regReq.rd && hit(regReq, NARROW_DATA_ADDR)
            |=> regRdata[i] == ($past(narrowDir_q[i]) ? $past(narrowData_q[i]) : $past(narrowSync_q[i])))
            else $error("Narrow pin readback wrong.");

        // An unclaimed pin is plain general purpose I/O.
        narrow_bit_gpio_a: assert property (@(posedge clk_sys) disable iff (srst)
            clkEn && !narrowClaim[i]
            |=> narrowPin.out[i] == $past(narrowData_q[i])
            && narrowPin.oe[i] == $past(narrowDir_q[i]))
            else $error("Unclaimed narrow pin not general purpose.");

        // A claimed pin carries the link's value and direction.
        narrow_bit_link_a: assert property (@(posedge clk_sys) disable iff (srst)
            clkEn && narrowClaim[i]
            |=> narrowPin.out[i] == $past(linkNarrowOut[i])
            && narrowPin.oe[i] == $past(linkNarrowOe[i]))
            else $error("Claimed narrow pin not driven by link.");
    end

endmodule

/* sim/die_link_model.sv */
// Behavioural model of the die-link interface sitting on the far side of the pins.
`timescale 1ns/1ps
module die_link_model
    import die_link_port_pkg::*;
(
    // Drive value and enable that the link puts on the pins it claims.
    output logic [1:0] narrowOut,
    output logic [1:0] narrowOe,
    output logic [7:0] wideOut,
    output logic [7:0] wideOe
);
    // The link drives a fixed, uneven pattern so that a swapped bit shows.
    assign narrowOut = 2'h3;
    assign narrowOe = 2'h2;
    assign wideOut = 8'ha5;
    assign wideOe = 8'h3c;
endmodule

/* sim/tb_die_link_port_pin_control.sv */
// Self-checking bench for the die-link port pin control block.
`timescale 1ns/1ps
module tb_die_link_port_pin_control
    import die_link_port_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    reg_req_s req = '0;
    logic [7:0] regRdata;
    logic linkEnable = 1'b0;
    link_width_e linkWidth = LINK_NIBBLE;
    logic clkClaim = 1'b0;
    logic intClaim = 1'b0;
    logic [1:0] lnOut, lnOe, linkNarrowIn;
    logic [7:0] lwOut, lwOe, linkWideIn;
    logic [1:0] nPad = 2'h0;
    logic [7:0] wPad = 8'h00;
    pin_drive_s narrowPin, widePin;
    int errors = 0;
    int n_tests = 0;
    // Rows: direction, data, pad level, expected readback.
    logic [7:0] rows [4][4] = '{'{8'hff, 8'h5a, 8'h00, 8'h5a}, '{8'h00, 8'h5a, 8'hc3, 8'hc3},
        '{8'h0f, 8'ha5, 8'h3c, 8'h35}, '{8'hf0, 8'h12, 8'h9e, 8'h1e}};
    always #20 clk_sys = ~clk_sys;
    die_link_model link (.narrowOut(lnOut), .narrowOe(lnOe), .wideOut(lwOut), .wideOe(lwOe));
    die_link_port_pin_control dut (.clk_sys(clk_sys), .srst(srst), .clkEn(1'b1), .regReq(req),
        .regRdata(regRdata), .linkEnable(linkEnable), .linkWidth(linkWidth), .linkClockClaim(clkClaim),
        .linkIntClaim(intClaim), .linkNarrowOut(lnOut), .linkNarrowOe(lnOe), .linkWideOut(lwOut),
        .linkWideOe(lwOe), .linkNarrowIn(linkNarrowIn), .linkWideIn(linkWideIn), .narrowPinIn(nPad),
        .widePinIn(wPad), .narrowPin(narrowPin), .widePin(widePin));
    // Prints one mismatch line and counts every comparison.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe; the next task waits for a fresh edge, so strobes never collide.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are looked at mid-cycle there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        @(negedge clk_sys);
        chk(what, exp, regRdata);
    endtask
    // Lets pins, synchronisers and pad flops settle.
    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("Tests %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog far beyond the fewer than one hundred cycles the sequence needs.
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        chk("wide oe after reset", 8'h00, widePin.oe);
        for (int a = 4; a < 8; a++) begin
            rd(8'(a), 8'h00, "reset value");
        end
        // Ordinary wide-port cases with the link off.
        foreach (rows[i]) begin
            wr(WIDE_DIR_ADDR, rows[i][0]);
            wr(WIDE_DATA_ADDR, rows[i][1]);
            wPad <= rows[i][2];
            settle();
            chk("wide oe", rows[i][0], widePin.oe);
            chk("wide out", rows[i][1] & rows[i][0], widePin.out & widePin.oe);
            rd(WIDE_DATA_ADDR, rows[i][3], "wide read");
        end
        wr(NARROW_DIR_ADDR, 8'hff);
        wr(NARROW_DATA_ADDR, 8'hff);
        settle();
        chk("narrow oe", 8'h03, narrowPin.oe);
        rd(NARROW_DIR_ADDR, 8'h03, "narrow dir");
        rd(NARROW_DATA_ADDR, 8'h03, "narrow data");
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h00, "unmapped read");
        wr(NARROW_DIR_ADDR, 8'h01);
        // Eight-bit link mode with both narrow pins claimed.
        linkEnable <= 1'b1;
        linkWidth <= LINK_BYTE;
        clkClaim <= 1'b1;
        intClaim <= 1'b1;
        nPad <= 2'h2;
        settle();
        chk("narrow link in", 8'h02, {6'h00, linkNarrowIn});
        chk("narrow link out", 8'h03, narrowPin.out);
        chk("byte oe", 8'h3c, widePin.oe);
        chk("byte out", 8'h24, widePin.out & widePin.oe);
        chk("byte in", 8'h9e, linkWideIn);
        chk("narrow link oe", 8'h02, narrowPin.oe);
        rd(WIDE_DIR_ADDR, 8'hf0, "dir kept");
        // Four-bit mode, interrupt pin only, then clock pin only.
        linkWidth <= LINK_NIBBLE;
        clkClaim <= 1'b0;
        settle();
        chk("nibble oe", 8'hfc, widePin.oe);
        chk("nibble in", 8'h0e, linkWideIn);
        chk("int only oe", 8'h03, narrowPin.oe);
        clkClaim <= 1'b1;
        intClaim <= 1'b0;
        settle();
        chk("clk only oe", 8'h00, narrowPin.oe);
        chk("clk only in", 8'h00, {6'h00, linkNarrowIn});
        end_of_test();
    end
endmodule
